// ### omm_defines.vh
// omm_defines.vh: memory map, reset values, bus and timing constants of the
// optical module management port. Definitions only, included by omm_*.v files.
`ifndef OMM_DEFINES_VH
`define OMM_DEFINES_VH

// 2-wire device address (7 bits); arbitrary neutral value
`define OMM_DEV_ADDR        7'h50

// memory map byte addresses
`define OMM_A_TEMP          8'h00
`define OMM_A_BIAS          8'h01
`define OMM_A_TXPWR         8'h02
`define OMM_A_RXPWR         8'h03
`define OMM_A_VCC           8'h04
`define OMM_A_STATUS        8'h05
`define OMM_A_MASK          8'h06
`define OMM_A_CTRL          8'h07
`define OMM_A_ALM_HI        8'h08
`define OMM_A_ALM_LO        8'h09
`define OMM_A_WRN_HI        8'h0a
`define OMM_A_WRN_LO        8'h0b
`define OMM_A_LIM_BASE      8'h10
`define OMM_A_LIM_LAST      8'h23
`define OMM_A_USER_BASE     8'h40
`define OMM_A_USER_LAST     8'h47

// status byte fields
`define OMM_ST_LASER_ON     0
`define OMM_ST_LOS          1
`define OMM_ST_NOT_READY    2
`define OMM_ST_STANDBY      3
`define OMM_ST_SELECTED     4

// control byte fields
`define OMM_CT_SOFT_OFF     0

// reset values
`define OMM_MASK_RST        8'h1f
`define OMM_CTRL_RST        8'h00

// limits, per channel 32 bits {hi alarm, lo alarm, hi warn, lo warn}, ch0 low
`define OMM_LIMITS_RST      160'he0_10_d0_20_e0_10_d0_20_e0_10_d0_20_e0_10_d0_20_e0_10_d0_20

// laser-off deadline
`define OMM_CLK_NS          5
`define OMM_LASER_OFF_NS    10000
`define OMM_LASER_OFF_CYC   (`OMM_LASER_OFF_NS / `OMM_CLK_NS)

`endif

// ### omm_host_model.sv
// omm_host_model.sv: behavioural host controller of the 2-wire bus.
// assumes the bench resolves the pulled-up data wire from both open drains.
`default_nettype none
module omm_host_model
(
  input  wire logic       i_sda,
  output var  logic       o_scl,
  output var  logic       o_sda_low,
  output var  logic       o_rd_stb,
  output var  logic [7:0] o_rd_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 32;
  // idle bus: clock stands high, data left to the pull-up
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    o_rd_stb = 1'b0;
    o_rd_byte = 8'h00;
  end
  // one bit of 64 ns; data moves only in the low phase
  task automatic bit_slot(input logic b, output logic s);
    o_sda_low = !b;
    #(HALF / 2);
    o_scl = 1'b1;
    #HALF;
    s = i_sda;
    o_scl = 1'b0;
    #(HALF / 2);
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start();
    o_sda_low = 1'b0;
    #(HALF / 2);
    o_scl = 1'b1;
    #HALF;
    o_sda_low = 1'b1;
    #HALF;
    o_scl = 1'b0;
    #(HALF / 2);
  endtask
  // stop: data rises while the clock is high, bus left idle
  task automatic stop();
    o_sda_low = 1'b1;
    #(HALF / 2);
    o_scl = 1'b1;
    #HALF;
    o_sda_low = 1'b0;
    #HALF;
  endtask
  // msb first, then the acknowledge slot with data released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_slot(b[i], s);
    bit_slot(1'b1, s);
    ack = !s;
  endtask
  // last byte gets a nack so the module lets go of the wire
  task automatic recv_byte(input logic last);
    logic [7:0] r;
    logic       s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_slot(1'b1, s);
      r[i] = s;
    end
    bit_slot(last, s);
    o_rd_byte = r;
    o_rd_stb = 1'b1;
    #1;
    o_rd_stb = 1'b0;
  endtask
endmodule // omm_host_model
`default_nettype wire

// ### omm_mgmt_port.v
// omm_mgmt_port.v: management logic of a pluggable optical module: pins,
// diagnostics memory map, alarm/warning flags and the 2-wire slave.
// assumes monitor values come from adc logic on i_clk_sys; pins are asynchronous.
`default_nettype none
`include "omm_defines.vh"

// Function
// - bus answered only while select held low
// - interrupt low flags a readable condition
// - laser off while disable input asserted
// - laser off within ten microseconds
// - not ready is LOS or any lock loss
// - LOS high without signal, low otherwise
// - absent output tied low permanently
// - power down high keeps module standby
// - power down falling edge fully resets
// - reference clock inputs ignored entirely
// - write sampled on rise, protected areas kept
// - read data launched on clock fall
// - byte map, random or auto-increment access
// - live temperature, bias, powers, supply readable
// - alarm and warning flags on range exit
module omm_mgmt_port
#(
  parameter [159:0] P_LIMITS = `OMM_LIMITS_RST
)
(
  input  wire       i_clk_sys,
  input  wire       i_reset,
  input  wire       i_ce,
  input  wire       i_mod_select_n,
  input  wire       i_laser_off_request,
  input  wire       i_pdown_rst,
  input  wire       i_ext_ref_clock_pos,
  input  wire       i_ext_ref_clock_neg,
  input  wire       i_scl,
  input  wire       i_sda,
  output wire       o_sda_out,
  output wire       o_sda_oe,
  input  wire       i_rx_signal_absent,
  input  wire       i_tx_lock_lost,
  input  wire       i_rx_lock_lost,
  input  wire [7:0] i_temp,
  input  wire [7:0] i_bias,
  input  wire [7:0] i_txpwr,
  input  wire [7:0] i_rxpwr,
  input  wire [7:0] i_vcc,
  output reg        o_interrupt_n,
  output wire       o_mod_absent,
  output reg        o_not_ready_flag,
  output reg        o_receive_signal_lost,
  output reg        o_laser_enable,
  output reg        o_standby
);

  localparam integer NCH = 5;

  // synchronisers: stage 0 feeds stage 1 only
  reg [1:0] sel_s_r;
  reg [1:0] off_s_r;
  reg [2:0] pd_s_r;
  reg [1:0] los_s_r;
  reg [1:0] tlol_s_r;
  reg [1:0] rlol_s_r;

  reg [7:0] val_r [0:NCH-1];
  reg [7:0] user_r [0:7];
  reg [7:0] mask_r;
  reg [7:0] ctrl_r;
  reg [4:0] alm_hi_r;
  reg [4:0] alm_lo_r;
  reg [4:0] wrn_hi_r;
  reg [4:0] wrn_lo_r;
  reg [7:0] rdata_nxt;

  wire [4:0] alm_hi_ev;
  wire [4:0] alm_lo_ev;
  wire [4:0] wrn_hi_ev;
  wire [4:0] wrn_lo_ev;
  wire [7:0] twi_addr;
  wire [7:0] twi_wdata;
  wire       twi_wr;
  wire       twi_rd;
  wire       selected;
  wire       pd_fall;
  wire       soft_rst;
  wire [7:0] status;
  wire [7:0] lim_idx;
  wire [7:0] user_idx;
  integer    k;
  integer    j;

  // the reference clock pins are deliberately left unread
  wire unused_ref = i_ext_ref_clock_pos ^ i_ext_ref_clock_neg;

  assign selected = ~sel_s_r[1];
  assign pd_fall  = ~pd_s_r[1] & pd_s_r[2];
  assign soft_rst = pd_fall;
  assign lim_idx  = twi_addr - `OMM_A_LIM_BASE;
  assign user_idx = twi_addr - `OMM_A_USER_BASE;

  assign o_mod_absent = 1'b0;

  // pin synchronisers, all through two flops before use
  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      sel_s_r  <= 2'h3;
      off_s_r  <= 2'h3;
      pd_s_r   <= 3'h0;
      los_s_r  <= 2'h3;
      tlol_s_r <= 2'h0;
      rlol_s_r <= 2'h0;
    end
    else if (i_ce)
    begin
      sel_s_r  <= {sel_s_r[0], i_mod_select_n};
      off_s_r  <= {off_s_r[0], i_laser_off_request};
      pd_s_r   <= {pd_s_r[1:0], i_pdown_rst};
      los_s_r  <= {los_s_r[0], i_rx_signal_absent};
      tlol_s_r <= {tlol_s_r[0], i_tx_lock_lost};
      rlol_s_r <= {rlol_s_r[0], i_rx_lock_lost};
    end
  end

  omm_twi_slave u_twi
  (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_ce      (i_ce),
    .i_clr     (soft_rst),
    .i_enable  (selected),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .o_sda_out (o_sda_out),
    .o_sda_oe  (o_sda_oe),
    .o_addr    (twi_addr),
    .i_rdata   (rdata_nxt),
    .o_wr_stb  (twi_wr),
    .o_wdata   (twi_wdata),
    .o_rd_stb  (twi_rd)
  );

  // range comparators, one per monitored channel
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      wire [7:0] hi_alm = P_LIMITS[g*32+24 +: 8];
      wire [7:0] lo_alm = P_LIMITS[g*32+16 +: 8];
      wire [7:0] hi_wrn = P_LIMITS[g*32+8 +: 8];
      wire [7:0] lo_wrn = P_LIMITS[g*32 +: 8];
      assign alm_hi_ev[g] = (val_r[g] > hi_alm);
      assign alm_lo_ev[g] = (val_r[g] < lo_alm);
      assign wrn_hi_ev[g] = (val_r[g] > hi_wrn);
      assign wrn_lo_ev[g] = (val_r[g] < lo_wrn);
    end
  endgenerate

  // live diagnostic values; frozen in standby so stale readings are not flagged
  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      for (k = 0; k < NCH; k = k + 1)
        val_r[k] <= 8'h80;
    end
    else if (i_ce)
    begin
      if (soft_rst)
      begin
        for (k = 0; k < NCH; k = k + 1)
          val_r[k] <= 8'h80;
      end
      else if (!o_standby)
      begin
        val_r[0] <= i_temp;
        val_r[1] <= i_bias;
        val_r[2] <= i_txpwr;
        val_r[3] <= i_rxpwr;
        val_r[4] <= i_vcc;
      end
    end
  end

  // sticky flags: clear on read of their byte, a new event wins over the clear
  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      alm_hi_r <= 5'h00;
      alm_lo_r <= 5'h00;
      wrn_hi_r <= 5'h00;
      wrn_lo_r <= 5'h00;
    end
    else if (i_ce)
    begin
      if (soft_rst)
      begin
        alm_hi_r <= 5'h00;
        alm_lo_r <= 5'h00;
        wrn_hi_r <= 5'h00;
        wrn_lo_r <= 5'h00;
      end
      else
      begin
        alm_hi_r <= (twi_rd && twi_addr == `OMM_A_ALM_HI) ? alm_hi_ev : (alm_hi_r | alm_hi_ev);
        alm_lo_r <= (twi_rd && twi_addr == `OMM_A_ALM_LO) ? alm_lo_ev : (alm_lo_r | alm_lo_ev);
        wrn_hi_r <= (twi_rd && twi_addr == `OMM_A_WRN_HI) ? wrn_hi_ev : (wrn_hi_r | wrn_hi_ev);
        wrn_lo_r <= (twi_rd && twi_addr == `OMM_A_WRN_LO) ? wrn_lo_ev : (wrn_lo_r | wrn_lo_ev);
      end
    end
  end

  // writable bytes; everything else is write protected and only acknowledged
  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      mask_r <= `OMM_MASK_RST;
      ctrl_r <= `OMM_CTRL_RST;
      for (j = 0; j < 8; j = j + 1)
        user_r[j] <= 8'h00;
    end
    else if (i_ce)
    begin
      if (soft_rst)
      begin
        mask_r <= `OMM_MASK_RST;
        ctrl_r <= `OMM_CTRL_RST;
        for (j = 0; j < 8; j = j + 1)
          user_r[j] <= 8'h00;
      end
      else if (twi_wr)
      begin
        if (twi_addr == `OMM_A_MASK)
          mask_r <= twi_wdata;
        else if (twi_addr == `OMM_A_CTRL)
          ctrl_r <= twi_wdata;
        else if (twi_addr >= `OMM_A_USER_BASE && twi_addr <= `OMM_A_USER_LAST)
          user_r[user_idx[2:0]] <= twi_wdata;
      end
    end
  end

  assign status = {3'h0, selected, o_standby, o_not_ready_flag, o_receive_signal_lost, o_laser_enable};

  // read mux; unmapped bytes read as zero
  always @*
  begin
    rdata_nxt = 8'h00;
    if (twi_addr < 8'h05)
      rdata_nxt = val_r[twi_addr[2:0]];
    else if (twi_addr == `OMM_A_STATUS)
      rdata_nxt = status;
    else if (twi_addr == `OMM_A_MASK)
      rdata_nxt = mask_r;
    else if (twi_addr == `OMM_A_CTRL)
      rdata_nxt = ctrl_r;
    else if (twi_addr == `OMM_A_ALM_HI)
      rdata_nxt = {3'h0, alm_hi_r};
    else if (twi_addr == `OMM_A_ALM_LO)
      rdata_nxt = {3'h0, alm_lo_r};
    else if (twi_addr == `OMM_A_WRN_HI)
      rdata_nxt = {3'h0, wrn_hi_r};
    else if (twi_addr == `OMM_A_WRN_LO)
      rdata_nxt = {3'h0, wrn_lo_r};
    else if (twi_addr >= `OMM_A_LIM_BASE && twi_addr <= `OMM_A_LIM_LAST)
      rdata_nxt = P_LIMITS[{lim_idx[4:0], 3'h0} +: 8];
    else if (twi_addr >= `OMM_A_USER_BASE && twi_addr <= `OMM_A_USER_LAST)
      rdata_nxt = user_r[user_idx[2:0]];
  end

  // pin outputs, registered; laser path is 3 cycles, far inside the deadline
  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_interrupt_n         <= 1'b1;
      o_not_ready_flag      <= 1'b1;
      o_receive_signal_lost <= 1'b1;
      o_laser_enable        <= 1'b0;
      o_standby             <= 1'b0;
    end
    else if (i_ce)
    begin
      o_standby             <= pd_s_r[1];
      o_laser_enable        <= ~off_s_r[1] & ~pd_s_r[1] & ~ctrl_r[`OMM_CT_SOFT_OFF] & ~soft_rst;
      o_receive_signal_lost <= los_s_r[1];
      o_not_ready_flag      <= los_s_r[1] | tlol_s_r[1] | rlol_s_r[1];
      o_interrupt_n         <= ~(|((alm_hi_r | alm_lo_r | wrn_hi_r | wrn_lo_r) & mask_r[4:0]));
    end
  end

endmodule // omm_mgmt_port
`default_nettype wire

// ### omm_mgmt_port_checker.sv
// omm_mgmt_port_checker.sv: pin and bus-drive assertions of the management port.
// assumes it is bound to omm_mgmt_port and sees that module's ports only.
`default_nettype none
module omm_mgmt_port_checker
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_mod_select_n,
  input wire logic i_laser_off_request,
  input wire logic i_pdown_rst,
  input wire logic i_scl,
  input wire logic i_rx_signal_absent,
  input wire logic i_tx_lock_lost,
  input wire logic i_rx_lock_lost,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_mod_absent,
  input wire logic o_not_ready_flag,
  input wire logic o_receive_signal_lost,
  input wire logic o_laser_enable,
  input wire logic o_standby
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // pins pass two sync flops and a register; 8 calm cycles also outlast a soft reset
  wire logic fault_any = i_rx_signal_absent | i_tx_lock_lost | i_rx_lock_lost;
  not_ready_or_a: assert property (
    ($stable(fault_any) && !i_pdown_rst && $stable(i_pdown_rst)) [*8] |-> o_not_ready_flag == fault_any)
    else $error("not ready differs from the fault inputs");
  los_follow_a: assert property (
    ($stable(i_rx_signal_absent) && !i_pdown_rst && $stable(i_pdown_rst)) [*8]
    |-> o_receive_signal_lost == i_rx_signal_absent)
    else $error("loss of signal differs from its input");
  // a low clock enable freezes the sync flops, so only enabled cycles count
  laser_off_a: assert property ((i_laser_off_request && i_ce) [*4] |-> !o_laser_enable)
    else $error("laser still on while disabled");
  standby_hold_a: assert property (i_pdown_rst [*4] |-> o_standby)
    else $error("standby missing while power down high");
  absent_low_a: assert property (o_mod_absent == 1'b0)
    else $error("absent output not low");
  open_drain_a: assert property (o_sda_out == 1'b0)
    else $error("data pin driven high");
  deselect_quiet_a: assert property (i_mod_select_n [*4] |-> !o_sda_oe)
    else $error("data pin driven while deselected");
  // data changes only while the serial clock is low, after its fall
  sda_on_fall_a: assert property (
    $changed(o_sda_oe) && !i_mod_select_n && !i_pdown_rst |-> !i_scl && !$past(i_scl))
    else $error("data pin changed with serial clock high");
endmodule // omm_mgmt_port_checker

bind omm_mgmt_port omm_mgmt_port_checker u_chk (.*);
`default_nettype wire

// ### omm_mgmt_port_tb_top.sv
// omm_mgmt_port_tb_top.sv: self-checking bench of the management port.
// assumes the host model drives the bus and the checker is bound to the design.
`default_nettype none
`include "omm_defines.vh"
module omm_mgmt_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0]   AW = {`OMM_DEV_ADDR, 1'b0};
  localparam logic [7:0]   AR = {`OMM_DEV_ADDR, 1'b1};
  localparam logic [159:0] LIM = `OMM_LIMITS_RST;
  logic       i_clk_sys = 1'b0;
  logic       i_reset = 1'b1;
  logic       i_ce = 1'b1;
  logic       i_mod_select_n = 1'b0;
  logic       i_laser_off_request = 1'b0;
  logic       i_pdown_rst = 1'b0;
  logic       i_ext_ref_clock_pos = 1'b0;
  wire logic  i_ext_ref_clock_neg = ~i_ext_ref_clock_pos;
  logic       i_rx_signal_absent = 1'b0;
  logic       i_tx_lock_lost = 1'b0;
  logic       i_rx_lock_lost = 1'b0;
  logic [7:0] i_temp = 8'h80;
  logic [7:0] i_bias = 8'h80;
  logic [7:0] i_txpwr = 8'h80;
  logic [7:0] i_rxpwr = 8'h80;
  logic [7:0] i_vcc = 8'h80;
  wire logic  i_scl;
  wire logic  sda_low;
  wire logic  rd_stb;
  wire logic  [7:0] rd_byte;
  wire logic  o_sda_out;
  wire logic  o_sda_oe;
  wire logic  o_interrupt_n;
  wire logic  o_mod_absent;
  wire logic  o_not_ready_flag;
  wire logic  o_receive_signal_lost;
  wire logic  o_laser_enable;
  wire logic  o_standby;
  wire logic  i_sda = !(sda_low || (o_sda_oe && !o_sda_out));
  logic [7:0] exp_q [$];
  int         errors = 0;
  int         num_checks = 0;
  int         cyc = 0;

  omm_mgmt_port u_dut (.*);
  omm_host_model u_host (.i_sda(i_sda), .o_scl(i_scl), .o_sda_low(sda_low), .o_rd_stb(rd_stb), .o_rd_byte(rd_byte));

  // clock, and a reference clock that the design must not care about
  always #2.5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) i_ext_ref_clock_pos <= #1 ~i_ext_ref_clock_pos;

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  // pins set after a tick move 1 ns after a rising edge; the host model's bus lines keep their own timing
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // in-range monitor value, strictly inside every default warning window
  function automatic logic [7:0] rnd();
    return 8'h21 + 8'($urandom % 175);
  endfunction
  task automatic wr(input logic [7:0] dev, input logic [7:0] ptr, input logic [7:0] d[$], output logic ok);
    logic a;
    u_host.start();
    u_host.send_byte(dev, ok);
    u_host.send_byte(ptr, a);
    ok = ok & a;
    foreach (d[i])
    begin
      u_host.send_byte(d[i], a);
      ok = ok & a;
    end
    u_host.stop();
    tick(2);
  endtask
  // pointer write, repeated start, then sequential reads noted for the monitor
  task automatic rd(input logic [7:0] ptr, input logic [7:0] e[$]);
    logic a;
    u_host.start();
    u_host.send_byte(AW, a);
    u_host.send_byte(ptr, a);
    u_host.start();
    u_host.send_byte(AR, a);
    foreach (e[i])
    begin
      exp_q.push_back(e[i]);
      u_host.recv_byte(i == e.size() - 1);
    end
    u_host.stop();
    tick(2);
  endtask
  // each byte the host takes retires the oldest note
  always @(posedge rd_stb)
    check("read byte", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx, rd_byte);
  // a hang is cut short well past the expected run of about 10000 cycles
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      final_report();
    end
  end

  initial
  begin
    logic       ok;
    logic [7:0] d [$];
    void'($urandom(29043));
    tick(4);
    i_reset = 1'b0;
    tick(4);
    check("absent", 8'h00, {7'h0, o_mod_absent});
    check("int idle", 8'h01, {7'h0, o_interrupt_n});
    rd(`OMM_A_STATUS, {8'h11, `OMM_MASK_RST, `OMM_CTRL_RST});
    $display("test reset done");
    for (int k = 0; k < 8; k++)
    begin
      {i_rx_signal_absent, i_tx_lock_lost, i_rx_lock_lost} = k[2:0];
      tick(4);
      check("not ready", {7'h0, |k[2:0]}, {7'h0, o_not_ready_flag});
      check("los", {7'h0, k[2]}, {7'h0, o_receive_signal_lost});
    end
    {i_rx_signal_absent, i_tx_lock_lost, i_rx_lock_lost} = 3'h0;
    check("laser on", 8'h01, {7'h0, o_laser_enable});
    // clock enable low must freeze the laser path too
    i_ce = 1'b0;
    i_laser_off_request = 1'b1;
    tick(4);
    check("ce frozen", 8'h01, {7'h0, o_laser_enable});
    i_ce = 1'b1;
    tick(4);
    check("laser off", 8'h00, {7'h0, o_laser_enable});
    i_laser_off_request = 1'b0;
    $display("test pins done");
    d = {rnd(), rnd(), rnd(), rnd()};
    wr(AW, `OMM_A_USER_BASE, d, ok);
    check("write ack", 8'h01, {7'h0, ok});
    rd(`OMM_A_USER_BASE, d);
    rd(`OMM_A_USER_BASE + 8'h02, {d[2]});
    wr(AW, `OMM_A_LIM_BASE, {~LIM[7:0]}, ok);
    check("protected ack", 8'h01, {7'h0, ok});
    rd(`OMM_A_LIM_BASE, {LIM[7:0]});
    wr(AW, `OMM_A_CTRL, {8'h01}, ok);
    check("soft off", 8'h00, {7'h0, o_laser_enable});
    wr(AW, `OMM_A_CTRL, {8'h00}, ok);
    check("soft on", 8'h01, {7'h0, o_laser_enable});
    $display("test memory done");
    i_mod_select_n = 1'b1;
    tick(4);
    wr(AW, `OMM_A_USER_BASE + 8'h01, {~d[1]}, ok);
    check("deselected ack", 8'h00, {7'h0, ok});
    i_mod_select_n = 1'b0;
    tick(4);
    rd(`OMM_A_USER_BASE + 8'h01, {d[1]});
    $display("test select done");
    d = {rnd(), rnd(), rnd(), rnd(), rnd()};
    {i_temp, i_bias, i_txpwr, i_rxpwr, i_vcc} = {d[0], d[1], d[2], d[3], d[4]};
    tick(4);
    rd(`OMM_A_TEMP, d);
    i_temp = 8'hf0;
    tick(4);
    check("int raised", 8'h00, {7'h0, o_interrupt_n});
    wr(AW, `OMM_A_MASK, {8'h1e}, ok);
    check("int masked", 8'h01, {7'h0, o_interrupt_n});
    wr(AW, `OMM_A_MASK, {8'h1f}, ok);
    i_temp = d[0];
    tick(4);
    check("int unmasked", 8'h00, {7'h0, o_interrupt_n});
    rd(`OMM_A_ALM_HI, {8'h01});
    rd(`OMM_A_WRN_HI, {8'h01});
    rd(`OMM_A_ALM_HI, {8'h00});
    check("int released", 8'h01, {7'h0, o_interrupt_n});
    $display("test flags done");
    i_pdown_rst = 1'b1;
    tick(4);
    check("standby", 8'h01, {7'h0, o_standby});
    i_pdown_rst = 1'b0;
    tick(8);
    check("awake", 8'h00, {7'h0, o_standby});
    rd(`OMM_A_USER_BASE, {8'h00, 8'h00});
    rd(`OMM_A_MASK, {`OMM_MASK_RST});
    check("notes left", 8'h00, 8'(exp_q.size()));
    $display("test power down done");
    final_report();
  end
endmodule // omm_mgmt_port_tb_top
`default_nettype wire

// ### omm_twi_slave.v
// omm_twi_slave.v: 2-wire serial slave with byte address pointer.
// assumes scl/sda come from pins on another clock; they are synchronised here.
`default_nettype none
`include "omm_defines.vh"

module omm_twi_slave
(
  input  wire       i_clk_sys,
  input  wire       i_reset,
  input  wire       i_ce,
  input  wire       i_clr,
  input  wire       i_enable,
  input  wire       i_scl,
  input  wire       i_sda,
  output wire       o_sda_out,
  output reg        o_sda_oe,
  output wire [7:0] o_addr,
  input  wire [7:0] i_rdata,
  output reg        o_wr_stb,
  output reg  [7:0] o_wdata,
  output reg        o_rd_stb
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACKA = 3'h2;
  localparam [2:0] ST_WRB  = 3'h3;
  localparam [2:0] ST_ACKW = 3'h4;
  localparam [2:0] ST_RDB  = 3'h5;
  localparam [2:0] ST_RACK = 3'h6;

  reg [2:0] scl_s_r;
  reg [2:0] sda_s_r;
  reg [2:0] state_r;
  reg [3:0] cnt_r;
  reg [7:0] sh_r;
  reg [7:0] ptr_r;
  reg       first_r;
  reg       rd_r;

  // stage 0 is read only by stage 1; edges come from stages 1 and 2
  wire scl_rise = scl_s_r[1] & ~scl_s_r[2];
  wire scl_fall = ~scl_s_r[1] & scl_s_r[2];
  wire sda_now  = sda_s_r[1];
  wire start    = scl_s_r[1] & scl_s_r[2] & sda_s_r[2] & ~sda_s_r[1];
  wire stop     = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[2] & sda_s_r[1];

  assign o_sda_out = 1'b0; // open drain: only ever pulls low
  assign o_addr    = ptr_r;

  // pin synchronisers
  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
    end
    else if (i_ce)
    begin
      scl_s_r <= {scl_s_r[1:0], i_scl};
      sda_s_r <= {sda_s_r[1:0], i_sda};
    end
  end

  // protocol engine; data in on scl rise, data out on scl fall
  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_r  <= ST_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      ptr_r    <= 8'h00;
      first_r  <= 1'b0;
      rd_r     <= 1'b0;
      o_sda_oe <= 1'b0;
      o_wr_stb <= 1'b0;
      o_wdata  <= 8'h00;
      o_rd_stb <= 1'b0;
    end
    else if (i_ce)
    begin
      o_wr_stb <= 1'b0;
      o_rd_stb <= 1'b0;
      if (i_clr)
      begin
        state_r  <= ST_IDLE;
        cnt_r    <= 4'h0;
        ptr_r    <= 8'h00;
        o_sda_oe <= 1'b0;
      end
      else if (!i_enable)
      begin
        state_r  <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end
      else if (start)
      begin
        state_r  <= ST_ADDR;
        cnt_r    <= 4'h0;
        o_sda_oe <= 1'b0;
      end
      else if (stop)
      begin
        state_r  <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (state_r)
          ST_ADDR, ST_WRB:
          begin
            sh_r  <= {sh_r[6:0], sda_now};
            cnt_r <= cnt_r + 4'h1;
          end
          ST_RDB:
            cnt_r <= cnt_r + 4'h1;
          ST_RACK:
            if (sda_now)
              state_r <= ST_IDLE; // host nack ends the read
          default:
            cnt_r <= cnt_r;
        endcase
      end
      else if (scl_fall)
      begin
        case (state_r)
          ST_ADDR:
            if (cnt_r == 4'h8)
            begin
              if (sh_r[7:1] == `OMM_DEV_ADDR)
              begin
                o_sda_oe <= 1'b1;
                rd_r     <= sh_r[0];
                state_r  <= ST_ACKA;
              end
              else
                state_r <= ST_IDLE;
            end
          ST_ACKA:
          begin
            cnt_r <= 4'h0;
            if (rd_r)
            begin
              o_rd_stb <= 1'b1; // strobe while the pointer still names the latched byte
              sh_r     <= i_rdata;
              o_sda_oe <= ~i_rdata[7];
              state_r  <= ST_RDB;
            end
            else
            begin
              o_sda_oe <= 1'b0;
              first_r  <= 1'b1;
              state_r  <= ST_WRB;
            end
          end
          ST_WRB:
            if (cnt_r == 4'h8)
            begin
              o_sda_oe <= 1'b1;
              state_r  <= ST_ACKW;
              if (first_r)
                ptr_r <= sh_r;
              else
              begin
                o_wr_stb <= 1'b1;
                o_wdata  <= sh_r;
              end
            end
          // pointer steps only after the strobe, so a write lands where it was aimed
          ST_ACKW:
          begin
            o_sda_oe <= 1'b0;
            cnt_r    <= 4'h0;
            state_r  <= ST_WRB;
            if (first_r)
              first_r <= 1'b0;
            else
              ptr_r <= ptr_r + 8'h01;
          end
          ST_RDB:
            if (cnt_r == 4'h8)
            begin
              o_sda_oe <= 1'b0;
              ptr_r    <= ptr_r + 8'h01;
              state_r  <= ST_RACK;
            end
            else
            begin
              sh_r     <= {sh_r[6:0], 1'b0};
              o_sda_oe <= ~sh_r[6];
            end
          ST_RACK:
          begin
            o_rd_stb <= 1'b1;
            sh_r     <= i_rdata;
            o_sda_oe <= ~i_rdata[7];
            cnt_r    <= 4'h0;
            state_r  <= ST_RDB;
          end
          default:
            state_r <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // omm_twi_slave
`default_nettype wire
